// *** common/mms_pkg.sv ***
// constants and types of the motor mode sequencer
package mms_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SLEEP_MIN_MS = 100;
	localparam int unsigned SLEEP_MIN_CYC = CLK_HZ / 1000 * SLEEP_MIN_MS;
	localparam int unsigned RESTART_MS = 1000;
	localparam int unsigned RESTART_CYC = CLK_HZ / 1000 * RESTART_MS;
	localparam int unsigned SEC_CYC = CLK_HZ;
	localparam int unsigned NVM_LOAD_CYC = 16;
	localparam int unsigned CFG14_QUAL_BIT = 7;
	localparam int unsigned CFG19_TIME_LSB = 5;
	localparam int unsigned CFG19_MODE_BIT = 4;
	localparam int unsigned CFG19_HOLD_BIT = 3;
	localparam logic [2:0] EVT_ERR = 3'h0;
	localparam logic [2:0] EVT_SLEEP = 3'h1;
	localparam logic [2:0] EVT_START = 3'h2;
	localparam logic [2:0] EVT_STOP = 3'h3;
	localparam logic [2:0] EVT_IDLE = 3'h4;
	localparam int unsigned NUM_EVT = 5;
	localparam logic [1:0] ADR_STAT = 2'h0;
	localparam logic [1:0] ADR_CLR = 2'h1;
	localparam logic [1:0] ADR_EN = 2'h2;
	localparam logic [1:0] ADR_MODE = 2'h3;
	typedef enum logic [2:0] {
		MMS_LOAD = 3'b000,
		MMS_BRAKE = 3'b001,
		MMS_HOLD = 3'b010,
		MMS_IDLE = 3'b011,
		MMS_RUN = 3'b100,
		MMS_ERROR = 3'b101,
		MMS_SLEEP = 3'b110
	} mms_state_e;
	typedef enum logic [1:0] {
		MMS_GATE_OFF = 2'b00,
		MMS_GATE_BRAKE = 2'b01,
		MMS_GATE_DRIVE = 2'b10
	} mms_gate_e;
endpackage

// *** dv/mms_partner.sv ***
// stand-in for the startup block: reports done a few cycles into driving
module mms_partner #(
	parameter int unsigned LAT = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_go,
	input wire logic i_drive,
	output logic o_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt_ff;
	always_ff @(posedge i_ref_clk) begin
		cnt_ff <= i_drive ? cnt_ff + 1 : 0;
		o_done <= i_drive && (o_done || (i_go && cnt_ff >= LAT));
	end
endmodule

// *** dv/mms_seq_tb.sv ***
// self-checking bench of the motor mode sequencer
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module mms_seq_tb import mms_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned SC = 20;
	localparam int unsigned RD = 30;
	localparam int unsigned SEC = 10;
	logic clk = 0, rst = 1, pin = 1, fault = 0, wr = 0, rd = 0;
	logic done, irq, hiz, go, errl;
	logic [7:0] spd = 0, r14 = 0, r19 = 8'h50, wd = 0, rdata;
	logic [2:0] blk = 0, mode;
	logic [1:0] adr = 0, gate;
	int err_count = 0, num_checks = 0, n;
	mms_seq #(.SLEEP_CYC(SC), .RESTART_DLY(RD), .SEC_CYCLES(SEC)) dut (
		.i_ref_clk(clk), .i_rst(rst), .i_sleep_request_pin(pin), .i_speed_cmd(spd),
		.i_fault(fault), .i_nvm_reg14(r14), .i_nvm_reg19(r19),
		.i_max_output_off_cfg(blk[0]), .i_never_halt_cfg(blk[1]),
		.i_speed_invert_cfg(blk[2]), .i_startup_done(done), .i_reg_addr(adr),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_irq(irq), .o_mode(mode), .o_gate_state(gate), .o_gate_hiz(hiz),
		.o_startup_go(go), .o_error_latched(errl));
	mms_partner #(.LAT(4)) partner (.i_ref_clk(clk), .i_go(go),
		.i_drive(gate === MMS_GATE_DRIVE), .o_done(done));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wait_m(input logic [2:0] m, input int lim);
		n = 0;
		while (mode !== m && n < lim) begin
			@(negedge clk);
			n++;
		end
		`CHK(mode, m)
	endtask
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rreg(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		`CHK(rdata, e)
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wait_m(MMS_BRAKE, 40);
		`CHK(gate, MMS_GATE_BRAKE)
		wait_m(MMS_IDLE, 60);
		`CHK(n >= 2 * SEC && n <= 2 * SEC + 1, 1'b1)
		`CHK({gate, hiz}, {MMS_GATE_OFF, 1'b1})
		$display("test power-up brake done");
		wreg(ADR_CLR, 8'h1F);
		wreg(ADR_EN, 8'h04);
		wreg(ADR_STAT, 8'hFF);
		rreg(ADR_STAT, 8'h00);
		rreg(ADR_EN, 8'h04);
		rreg(ADR_CLR, 8'h00);
		`CHK(irq, 1'b0)
		@(posedge clk) spd <= 8'h05;
		wait_m(MMS_RUN, 2);
		`CHK({gate, go, irq}, {MMS_GATE_DRIVE, 2'b11})
		rreg(ADR_MODE, {5'h00, MMS_RUN});
		rreg(ADR_STAT, 8'h04);
		wreg(ADR_EN, 8'h00);
		`CHK(irq, 1'b0)
		wreg(ADR_CLR, 8'h04);
		rreg(ADR_STAT, 8'h00);
		`CHK(go, 1'b0)
		@(posedge clk) spd <= 8'h00;
		wait_m(MMS_IDLE, 2);
		rreg(ADR_STAT, 8'h18);
		$display("test run and registers done");
		@(posedge clk) spd <= 8'h05;
		wait_m(MMS_RUN, 2);
		@(posedge clk) fault <= 1'b1;
		wait_m(MMS_ERROR, 3);
		`CHK(errl, 1'b1)
		@(posedge clk) fault <= 1'b0;
		wait_m(MMS_RUN, RD + 3);
		`CHK(n >= RD - 2 && n <= RD + 1, 1'b1)
		@(posedge clk) fault <= 1'b1;
		wait_m(MMS_ERROR, 3);
		@(posedge clk) fault <= 1'b0;
		spd <= 8'h00;
		wait_m(MMS_IDLE, 2);
		@(posedge clk) spd <= 8'h05;
		wait_m(MMS_RUN, 2);
		@(posedge clk) fault <= 1'b1;
		wait_m(MMS_ERROR, 3);
		@(posedge clk) fault <= 1'b0;
		pin <= 1'b0;
		tick(SC / 2);
		`CHK(mode !== MMS_SLEEP, 1'b1)
		@(posedge clk) pin <= 1'b1;
		@(posedge clk) pin <= 1'b0;
		wait_m(MMS_SLEEP, SC + 3);
		`CHK(n >= SC - 1, 1'b1)
		`CHK({hiz, gate, errl}, {1'b1, MMS_GATE_OFF, 1'b0})
		$display("test error and sleep done");
		@(posedge clk) pin <= 1'b1;
		spd <= 8'h00;
		r19 <= 8'h38;
		r14 <= 8'h80;
		wait_m(MMS_LOAD, 3);
		wait_m(MMS_HOLD, 40);
		`CHK(gate, MMS_GATE_BRAKE)
		@(posedge clk) spd <= 8'h05;
		wait_m(MMS_RUN, 2);
		@(posedge clk) spd <= 8'h00;
		wait_m(MMS_IDLE, 2);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) blk <= 3'h1 << i;
			pin <= 1'b0;
			tick(SC + 10);
			`CHK(mode, MMS_IDLE)
		end
		@(posedge clk) blk <= 3'h0;
		spd <= 8'h05;
		tick(SC + 10);
		`CHK(mode, MMS_RUN)
		@(posedge clk) spd <= 8'h00;
		wait_m(MMS_SLEEP, SC + 4);
		@(posedge clk) r19 <= 8'h18;
		pin <= 1'b1;
		wait_m(MMS_IDLE, 20);
		$display("test qualified sleep and hold done");
		print_verdict();
	end
	initial begin
		#(50 * 5000);
		err_count++;
		print_verdict();
	end
endmodule

// *** logic/mms_seq.sv ***
// operating-mode sequencer top
//
// The placing of the registers and the address-and-strobe port were decided locally.
module mms_seq import mms_pkg::*; #(
	parameter int unsigned SLEEP_CYC = SLEEP_MIN_CYC,
	parameter int unsigned RESTART_DLY = RESTART_CYC,
	parameter int unsigned SEC_CYCLES = SEC_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_sleep_request_pin,
	input wire logic [7:0] i_speed_cmd,
	input wire logic i_fault,
	input wire logic [7:0] i_nvm_reg14,
	input wire logic [7:0] i_nvm_reg19,
	input wire logic i_max_output_off_cfg,
	input wire logic i_never_halt_cfg,
	input wire logic i_speed_invert_cfg,
	input wire logic i_startup_done,
	input wire logic [1:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_irq,
	output logic [2:0] o_mode,
	output logic [1:0] o_gate_state,
	output logic o_gate_hiz,
	output logic o_startup_go,
	output logic o_error_latched
);
	initial begin
		if (SLEEP_CYC < 1 || RESTART_DLY < 1 || SEC_CYCLES < 1) $error("mms_seq bad count");
	end
	mms_state_e state_ff, nxt_state;
	logic [7:0] cfg14_ff;
	logic [7:0] cfg19_ff;
	logic err_ff;
	logic [31:0] slp_cnt_ff;
	logic [NUM_EVT-1:0] stat_ff;
	logic [NUM_EVT-1:0] en_ff;
	logic [7:0] rdata_ff;
	logic tmr_load;
	logic [31:0] tmr_count;
	logic tmr_busy;
	logic tmr_done;
	logic [NUM_EVT-1:0] evt;
	wire spd_zero = (i_speed_cmd == 8'h00);
	wire qual = cfg14_ff[CFG14_QUAL_BIT];
	wire [2:0] brake_sec = cfg19_ff[CFG19_TIME_LSB +: 3];
	wire brake_short = cfg19_ff[CFG19_MODE_BIT];
	wire brake_hold = cfg19_ff[CFG19_HOLD_BIT] && (brake_sec != 3'h0);
	wire blocked = i_max_output_off_cfg || i_never_halt_cfg || i_speed_invert_cfg;
	wire cond_plain = !i_sleep_request_pin;
	wire cond_qual = !i_sleep_request_pin && spd_zero && !blocked;
	wire sleep_cond = qual ? cond_qual : cond_plain;
	wire in_sleep = (state_ff == MMS_SLEEP);
	wire sleep_req = sleep_cond && (slp_cnt_ff >= SLEEP_CYC - 1);
	// brake length in clocks from a seconds code
	function automatic logic [31:0] brake_cycles(input logic [2:0] sec);
		return 32'(32'(sec) * 32'(SEC_CYCLES));
	endfunction
	// timer is loaded in the same cycle as the config, so use the incoming NVM byte
	wire [31:0] brake_cyc = brake_cycles(i_nvm_reg19[CFG19_TIME_LSB +: 3]);
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !sleep_cond || in_sleep) begin
			slp_cnt_ff <= '0;
		end else if (slp_cnt_ff < SLEEP_CYC - 1) begin
			slp_cnt_ff <= slp_cnt_ff + 32'h1;
		end
	end
	mms_timer #(
		.WIDTH(32)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_busy(tmr_busy),
		.o_done(tmr_done)
	);
	always_comb begin
		nxt_state = state_ff;
		tmr_load = 1'b0;
		tmr_count = '0;
		if (sleep_req && !in_sleep) begin
			nxt_state = MMS_SLEEP;
		end else begin
			unique case (state_ff)
				MMS_LOAD: begin
					tmr_load = 1'b1;
					tmr_count = brake_cyc;
					nxt_state = MMS_BRAKE;
				end
				MMS_BRAKE: begin
					if (!tmr_busy) begin
						nxt_state = brake_hold ? MMS_HOLD : MMS_IDLE;
					end
				end
				MMS_HOLD: begin
					if (!spd_zero) begin
						nxt_state = MMS_RUN;
					end
				end
				MMS_IDLE: begin
					if (!spd_zero) begin
						nxt_state = MMS_RUN;
					end
				end
				MMS_RUN: begin
					if (i_fault) begin
						tmr_load = 1'b1;
						tmr_count = 32'(RESTART_DLY);
						nxt_state = MMS_ERROR;
					end else if (spd_zero) begin
						nxt_state = MMS_IDLE;
					end
				end
				MMS_ERROR: begin
					if (spd_zero) begin
						nxt_state = MMS_IDLE;
					end else if (tmr_done) begin
						nxt_state = MMS_RUN;
					end
				end
				MMS_SLEEP: begin
					if (!sleep_cond) begin
						nxt_state = MMS_LOAD;
					end
				end
				default: nxt_state = MMS_LOAD;
			endcase
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_ff <= MMS_SLEEP;
		end else begin
			state_ff <= nxt_state;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cfg14_ff <= 8'h00;
			cfg19_ff <= 8'h00;
		end else if (state_ff == MMS_LOAD) begin
			cfg14_ff <= i_nvm_reg14;
			cfg19_ff <= i_nvm_reg19;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || in_sleep) begin
			err_ff <= 1'b0;
		end else if (state_ff == MMS_RUN && i_fault) begin
			err_ff <= 1'b1;
		end else if (state_ff == MMS_ERROR && nxt_state != MMS_ERROR) begin
			err_ff <= 1'b0;
		end
	end
	assign evt[EVT_ERR] = (state_ff == MMS_RUN) && i_fault;
	assign evt[EVT_SLEEP] = (nxt_state == MMS_SLEEP) && !in_sleep;
	assign evt[EVT_START] = (nxt_state == MMS_RUN) && (state_ff != MMS_RUN);
	assign evt[EVT_STOP] = (state_ff == MMS_RUN) && (nxt_state == MMS_IDLE);
	assign evt[EVT_IDLE] = (nxt_state == MMS_IDLE) && (state_ff != MMS_IDLE);
	wire wr_clr = i_reg_wr && (i_reg_addr == ADR_CLR);
	wire wr_en = i_reg_wr && (i_reg_addr == ADR_EN);
	wire [NUM_EVT-1:0] clr_bits = wr_clr ? i_reg_wdata[NUM_EVT-1:0] : '0;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			stat_ff <= '0;
			en_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~clr_bits) | evt;
			if (wr_en) begin
				en_ff <= i_reg_wdata[NUM_EVT-1:0];
			end
		end
	end
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (i_reg_addr)
			ADR_STAT: rd_mux = 8'(stat_ff);
			ADR_EN: rd_mux = 8'(en_ff);
			ADR_MODE: rd_mux = {4'h0, err_ff, state_ff};
			ADR_CLR: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= i_reg_rd ? rd_mux : 8'h00;
		end
	end
	logic [1:0] gate;
	always_comb begin
		gate = MMS_GATE_OFF;
		if (state_ff == MMS_RUN) begin
			gate = MMS_GATE_DRIVE;
		end else if ((state_ff == MMS_BRAKE || state_ff == MMS_HOLD) && brake_short) begin
			gate = MMS_GATE_BRAKE;
		end
	end
	assign o_reg_rdata = rdata_ff;
	assign o_irq = |(stat_ff & en_ff);
	assign o_mode = state_ff;
	assign o_gate_state = gate;
	assign o_gate_hiz = (gate == MMS_GATE_OFF);
	assign o_startup_go = (state_ff == MMS_RUN) && !i_startup_done;
	assign o_error_latched = err_ff;

	AST_SLEEP_HIZ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		in_sleep |-> o_gate_hiz && !o_error_latched) else $error("sleep not hiz");
	AST_IDLE_OFF: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_IDLE |-> gate == MMS_GATE_OFF) else $error("idle drives");
	AST_START: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_IDLE && !spd_zero && !sleep_req |=> state_ff == MMS_RUN)
		else $error("no start");
	AST_STOP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_RUN && spd_zero && !i_fault && !sleep_req |=> state_ff == MMS_IDLE)
		else $error("no stop");
	AST_ERR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_RUN && i_fault && !sleep_req |=> state_ff == MMS_ERROR && err_ff)
		else $error("no error entry");
	AST_ERR_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_ERROR && spd_zero && !sleep_req |=> state_ff == MMS_IDLE)
		else $error("error not to idle");
	AST_SLEEP_MIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(in_sleep) |-> $past(sleep_cond) && ($past(slp_cnt_ff) >= SLEEP_CYC - 1))
		else $error("early sleep");
	sequence brake_done_hold;
		state_ff == MMS_BRAKE && !tmr_busy && brake_hold && !sleep_req;
	endsequence
	sequence err_expire;
		state_ff == MMS_ERROR && tmr_done && !spd_zero && !sleep_req;
	endsequence
	AST_HOLD_ENTRY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		brake_done_hold |=> state_ff == MMS_HOLD) else $error("no hold");
	AST_RESTART: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		err_expire |=> state_ff == MMS_RUN) else $error("no restart");
	AST_RDATA_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!$past(i_reg_rd) |-> o_reg_rdata == 8'h00) else $error("rdata not zero");
	AST_SET_WINS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		evt[EVT_START] && wr_clr && i_reg_wdata[EVT_START] |=> stat_ff[EVT_START])
		else $error("clear beat set");
	AST_SLEEP_EVT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(in_sleep) |-> stat_ff[EVT_SLEEP]) else $error("sleep event lost");
	AST_QUAL_BLOCK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		qual && blocked && !in_sleep |=> !in_sleep) else $error("blocked sleep");
	AST_BRAKE_GATE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_BRAKE && !brake_short |-> o_gate_hiz) else $error("brake gate");
	AST_HOLD_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_HOLD |-> brake_hold) else $error("hold without bit");
	AST_LOAD_BRAKE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_LOAD && !sleep_req |=> state_ff == MMS_BRAKE && cfg19_ff == $past(i_nvm_reg19))
		else $error("load seq");
	AST_PLAIN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!qual && i_sleep_request_pin |-> !sleep_cond) else $error("plain cond");
	AST_QUAL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		qual && !spd_zero |-> !sleep_cond) else $error("qual cond");
	AST_WAKE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		in_sleep && !sleep_cond |=> state_ff == MMS_LOAD) else $error("wake");
	AST_BRAKE_END: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == MMS_BRAKE && !tmr_busy && !brake_hold && !sleep_req |=> state_ff == MMS_IDLE)
		else $error("brake end");
	AST_BRAKE_TIME: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(state_ff == MMS_BRAKE) |-> tmr_busy == (brake_sec != 3'h0))
		else $error("brake time");
endmodule

// *** logic/mms_timer.sv ***
// down counter with load and one-cycle done pulse
module mms_timer import mms_pkg::*; #(
	parameter int unsigned WIDTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_count,
	output logic o_busy,
	output logic o_done
);
	initial begin
		if (WIDTH < 2) $error("mms_timer width too small");
	end
	logic [WIDTH-1:0] cnt_ff;
	logic busy_ff;
	wire last = busy_ff && (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || i_load) begin
			cnt_ff <= i_rst ? '0 : i_count;
			busy_ff <= !i_rst && (i_count != '0);
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 1'b1;
			busy_ff <= !last;
		end
	end
	assign o_busy = busy_ff;
	assign o_done = last;
endmodule
